// ===== core/adc_cal_seq.sv
// Summary of operation
// - setup write 0,1 unheld starts self-calibration
// - self-cal lasts six periods, then clears mode
// - one conversion three periods after self-cal
// - result valid high until nine periods pass
// - result valid rises in the cycle after the setup write
// - setup write 1,0 starts three-period zero-scale
// - zero-scale: result valid low after four periods
// - both mode bits start three-period full-scale
// - full-scale: result valid low after four periods
// - coefficients from midpoint or endpoints per coding
// - power-down bit stops work, bus stays alive
// - registers keep contents during power-down
// - high result valid stays high through power-down
// - low result valid rises on read in power-down
// - wake-up result after three periods plus pipeline
// - clock output keeps toggling unless disabled
// - filter hold freezes calibration and conversion
// - read raises flag; overwrite pulses 500 cycles or one period if shorter
// - coefficients go to calibrated channel's pair
// - period is 128 times decimation, doubled divided
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/10ps
module adc_cal_seq
   import adc_seq_pkg::*;
#(
   parameter int MOD_CYCLES = MOD_CYCLES_DEF   // master clocks per modulator cycle
) (
   input wire logic I_CLK,
   input wire logic I_RST_B,
   input wire logic [ADDR_W-1:0] I_ADDR,
   input wire logic [DATA_W-1:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic [DATA_W-1:0] I_SAMPLE,
   output logic [DATA_W-1:0] O_RDATA,
   output logic O_RESULT_VALID_N,
   output logic O_CLOCK_OUTPUT_PIN,
   output logic O_MOD_RESET
);

   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   // nine doubled slowest periods must fit the countdown
   if (MOD_CYCLES < 1 || MOD_CYCLES > 256) begin : g_bad_mod
      $error("MOD_CYCLES out of range 1..256");
   end

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   bus_req_s req;                                // bundled bus request
   seq_s st;                                     // registered state
   seq_s next_st;                                // next state
   logic [WAIT_W-1:0] odr;                       // one output period in clocks
   logic [8:0] dec;                              // selected decimation rate
   logic rd_data;                                // read of result register
   logic wr_setup;                               // write of setup register
   logic wr_comm;                                // write of comm register
   logic result_evt;                             // conversion result lands
   logic [1:0] wmode;                            // mode in setup write
   logic whold;                                  // hold in setup write

   assign req = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
   assign rd_data = req.rd && req.addr == ADDR_DATA;
   assign wr_setup = req.wr && req.addr == ADDR_SETUP;
   assign wr_comm = req.wr && req.addr == ADDR_COMM;
   assign wmode = {req.wdata[SETUP_MODE_HI], req.wdata[SETUP_MODE_LO]};
   assign whold = req.wdata[SETUP_HOLD];
   assign result_evt = (st.state == S_FIRST || st.state == S_RUN) && st.wait_cnt == WAIT_W'(1);

   // ----------------------------------------------------------------
   // period length from decimation and divide
   // ----------------------------------------------------------------
   // table lookup then scale by modulator length and divider
   always_comb begin
      dec = DEC_TABLE[{st.rng, st.fs}];
      odr = WAIT_W'(MOD_CYCLES * int'(dec) * (st.div ? 2 : 1));
   end

   // gain span from zero point to full-scale point
   function automatic logic [DATA_W-1:0] span(input logic [DATA_W-1:0] fsv,
                                             input logic [DATA_W-1:0] zero,
                                             input logic bip);
      logic [DATA_W-1:0] d;
      d = fsv - zero;
      // bipolar zero is midscale, so the half span is doubled
      span = bip ? {d[DATA_W-2:0], 1'b0} : d;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      // read of result register ends the valid window
      if (rd_data) begin
         next_st.rv_n = 1'b1;
         next_st.unread = 1'b0;
         next_st.pulse_cnt = '0;  // data taken, nothing left to flag
      end else if (st.pulse_cnt != '0) begin
         // overwrite pulse runs down then flags new data
         next_st.pulse_cnt = st.pulse_cnt - PULSE_W'(1);
         if (st.pulse_cnt == PULSE_W'(1)) begin
            next_st.rv_n = 1'b0;
         end
      end
      // sequencer steps, one countdown on the master clock
      unique case (st.state)
         S_HOLD, S_PDOWN: begin
            // frozen: nothing counts, registers keep contents
            next_st.wait_cnt = st.wait_cnt;
         end
         S_CAL: begin
            next_st.wait_cnt = st.wait_cnt - WAIT_W'(1);
            // self-cal zero half ends, capture internal zero
            if (st.cal_kind == MODE_SELF &&
                st.wait_cnt == WAIT_W'(int'(odr) * SELF_HALF_PERIODS)) begin
               next_st.offset[st.chan] = I_SAMPLE;
            end
            if (st.wait_cnt == WAIT_W'(1)) begin
               // calibration over: store coefficients, clear mode
               next_st.mode = MODE_NORMAL;
               next_st.state = S_FIRST;
               unique case (st.cal_kind)
                  MODE_ZERO: begin
                     next_st.offset[st.chan] = I_SAMPLE;
                     next_st.wait_cnt = WAIT_W'(int'(odr) * SYS_CONV_PERIODS);
                  end
                  MODE_FULL: begin
                     next_st.gain[st.chan] = span(I_SAMPLE, st.offset[st.chan], st.bipolar);
                     next_st.wait_cnt = WAIT_W'(int'(odr) * SYS_CONV_PERIODS);
                  end
                  default: begin
                     // self-calibration, internal full-scale point
                     next_st.gain[st.chan] = span(I_SAMPLE, st.offset[st.chan], st.bipolar);
                     next_st.wait_cnt = WAIT_W'(int'(odr) * SELF_CONV_PERIODS);
                  end
               endcase
            end
         end
         S_FIRST, S_RUN: begin
            next_st.wait_cnt = st.wait_cnt - WAIT_W'(1);
            if (result_evt) begin
               // new result; an unread one first pulses high
               next_st.data = I_SAMPLE;
               next_st.unread = 1'b1;
               next_st.state = S_RUN;
               next_st.wait_cnt = odr;
               if (st.unread && !st.rv_n && !rd_data) begin
                  next_st.rv_n = 1'b1;
                  next_st.pulse_cnt = PULSE_CYCLES;
               end else begin
                  next_st.rv_n = 1'b0;
                  next_st.pulse_cnt = '0;
               end
            end
         end
      endcase
      // register writes, acting on the sequencer afterwards
      if (req.wr) begin
         unique case (req.addr)
            ADDR_COMM: begin
               next_st.pd = req.wdata[COMM_PD];
               next_st.chan = req.wdata[COMM_CHAN];
               if (req.wdata[COMM_PD]) begin
                  // enter power-down; flag left as it stands
                  next_st.state = S_PDOWN;
                  next_st.pulse_cnt = '0;
               end else if (st.pd) begin
                  if (st.hold) begin
                     next_st.state = S_HOLD;
                  end else begin
                     // wake-up: three periods plus pipeline delay
                     next_st.state = S_FIRST;
                     next_st.wait_cnt = WAIT_W'(int'(odr) * FIRST_CONV_PERIODS + TP_CYCLES);
                  end
               end
            end
            ADDR_SETUP: begin
               next_st.hold = whold;
               next_st.bipolar = req.wdata[SETUP_BIP];
               next_st.mode = wmode;
               if (st.pd) begin
                  // settings stored, work waits for wake-up
                  next_st.state = S_PDOWN;
               end else if (whold) begin
                  next_st.state = S_HOLD;
                  next_st.pulse_cnt = '0;
               end else if (wmode != MODE_NORMAL) begin
                  // calibration start, flag raised at once
                  next_st.state = S_CAL;
                  next_st.cal_kind = wmode;
                  next_st.rv_n = 1'b1;
                  next_st.pulse_cnt = '0;
                  next_st.wait_cnt = (wmode == MODE_SELF) ?
                     WAIT_W'(int'(odr) * SELF_CAL_PERIODS) :
                     WAIT_W'(int'(odr) * SYS_CAL_PERIODS);
               end else if (st.state == S_HOLD) begin
                  // hold released in normal mode
                  next_st.state = S_FIRST;
                  next_st.wait_cnt = WAIT_W'(int'(odr) * FIRST_CONV_PERIODS);
               end
            end
            ADDR_CLOCK: begin
               next_st.fs = {req.wdata[CLOCK_FS1], req.wdata[CLOCK_FS0]};
               next_st.div = req.wdata[CLOCK_DIV];
               next_st.clk_dis = req.wdata[CLOCK_DIS];
               next_st.rng = req.wdata[CLOCK_RNG];
            end
            ADDR_OFS0: next_st.offset[0] = req.wdata;
            ADDR_GAIN0: next_st.gain[0] = req.wdata;
            ADDR_OFS1: next_st.offset[1] = req.wdata;
            ADDR_GAIN1: next_st.gain[1] = req.wdata;
            default: begin
               // result register is read only
               next_st.data = next_st.data;
            end
         endcase
      end
      // read data, valid in the cycle after the strobe
      next_st.rdata = '0;
      if (req.rd) begin
         unique case (req.addr)
            ADDR_COMM: begin
               next_st.rdata[COMM_PD] = st.pd;
               next_st.rdata[COMM_CHAN] = st.chan;
               next_st.rdata[COMM_RV] = st.rv_n;
            end
            ADDR_SETUP: begin
               next_st.rdata[SETUP_HOLD] = st.hold;
               next_st.rdata[SETUP_BIP] = st.bipolar;
               next_st.rdata[SETUP_MODE_HI] = st.mode[1];
               next_st.rdata[SETUP_MODE_LO] = st.mode[0];
            end
            ADDR_CLOCK: begin
               next_st.rdata[CLOCK_FS1] = st.fs[1];
               next_st.rdata[CLOCK_FS0] = st.fs[0];
               next_st.rdata[CLOCK_DIV] = st.div;
               next_st.rdata[CLOCK_DIS] = st.clk_dis;
               next_st.rdata[CLOCK_RNG] = st.rng;
            end
            ADDR_DATA: next_st.rdata = st.data;
            ADDR_OFS0: next_st.rdata = st.offset[0];
            ADDR_GAIN0: next_st.rdata = st.gain[0];
            ADDR_OFS1: next_st.rdata = st.offset[1];
            default: next_st.rdata = st.gain[1];
         endcase
      end
      // clock output free runs unless disabled, even powered down
      next_st.clk_out = st.clk_dis ? 1'b0 : ~st.clk_out;
      next_st.mod_reset = next_st.state == S_HOLD || next_st.state == S_PDOWN;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // synchronous active low reset, held in hold state
   always_ff @(posedge I_CLK) begin
      if (!I_RST_B) begin
         st <= '0;
         st.state <= S_HOLD;
         st.hold <= 1'b1;
         st.rv_n <= 1'b1;
         st.mod_reset <= 1'b1;
         st.data <= DATA_RST;
         st.offset <= {DATA_RST, DATA_RST};
         st.gain <= {GAIN_RST, GAIN_RST};
      end else begin
         st <= next_st;
      end
   end

   assign O_RDATA = st.rdata;
   assign O_RESULT_VALID_N = st.rv_n;
   assign O_CLOCK_OUTPUT_PIN = st.clk_out;
   assign O_MOD_RESET = st.mod_reset;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_B);

   sequence s_cal_cmd;
      wr_setup && !whold && wmode != MODE_NORMAL && !st.pd;
   endsequence
   sequence s_cal_end;
      st.state == S_CAL && st.wait_cnt == WAIT_W'(1) && !req.wr;
   endsequence

   property p_cal_start;
      s_cal_cmd |=> st.state == S_CAL && st.rv_n;
   endproperty
   a_cal_start: assert property (p_cal_start) else $error("calibration did not start");

   property p_self_len;
      s_cal_cmd ##0 wmode == MODE_SELF |=> st.wait_cnt == WAIT_W'(int'(odr) * SELF_CAL_PERIODS);
   endproperty
   a_self_len: assert property (p_self_len) else $error("self cal length wrong");

   property p_sys_len;
      s_cal_cmd ##0 wmode != MODE_SELF |=> st.wait_cnt == WAIT_W'(int'(odr) * SYS_CAL_PERIODS);
   endproperty
   a_sys_len: assert property (p_sys_len) else $error("system cal length wrong");

   property p_mode_clear;
      s_cal_end |=> st.mode == MODE_NORMAL && st.state == S_FIRST;
   endproperty
   a_mode_clear: assert property (p_mode_clear) else $error("mode bits not cleared");

   property p_conv_len;
      s_cal_end ##0 st.cal_kind == MODE_SELF |=> st.wait_cnt == WAIT_W'(int'(odr) * SELF_CONV_PERIODS);
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("post cal conversion wrong");

   property p_busy_high;
      st.state == S_CAL |-> O_RESULT_VALID_N;
   endproperty
   a_busy_high: assert property (p_busy_high) else $error("flag low during cal");

   property p_hold;
      st.hold |-> st.state == S_HOLD || st.state == S_PDOWN;
   endproperty
   a_hold: assert property (p_hold) else $error("work while filter held");

   property p_read_clear;
      rd_data && !result_evt |=> O_RESULT_VALID_N;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("read did not raise flag");

   property p_pulse;
      result_evt && st.unread && !st.rv_n && !rd_data && !req.wr |=> O_RESULT_VALID_N [*8];
   endproperty
   a_pulse: assert property (p_pulse) else $error("overwrite pulse missing");

   property p_pd_flag;
      st.state == S_PDOWN && !rd_data && !req.wr |=> O_RESULT_VALID_N == $past(O_RESULT_VALID_N);
   endproperty
   a_pd_flag: assert property (p_pd_flag) else $error("flag moved in power-down");

   property p_wake;
      wr_comm && !req.wdata[COMM_PD] && st.pd && !st.hold |=>
         st.wait_cnt == WAIT_W'(int'(odr) * FIRST_CONV_PERIODS + TP_CYCLES);
   endproperty
   a_wake: assert property (p_wake) else $error("wake-up delay wrong");

   property p_clk_run;
      I_RST_B && !st.clk_dis ##1 !st.clk_dis |-> O_CLOCK_OUTPUT_PIN != $past(O_CLOCK_OUTPUT_PIN);
   endproperty
   a_clk_run: assert property (p_clk_run) else $error("clock output stalled");

   property p_mirror;
      req.rd && req.addr == ADDR_COMM |=> O_RDATA[COMM_RV] == $past(O_RESULT_VALID_N);
   endproperty
   a_mirror: assert property (p_mirror) else $error("status bit differs from pin");

endmodule // adc_cal_seq

// ===== core/adc_seq_pkg.sv
package adc_seq_pkg;
   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 3;                   // register index width
   localparam int DATA_W = 16;                  // register data width
   localparam int WAIT_W = 21;                  // sequencer countdown width
   localparam int PULSE_W = 10;                 // overwrite pulse counter width

   // ----------------------------------------------------------------
   // register indices
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_COMM = 3'h0;   // power down, channel, status
   localparam logic [ADDR_W-1:0] ADDR_SETUP = 3'h1;  // mode, bipolar, filter hold
   localparam logic [ADDR_W-1:0] ADDR_CLOCK = 3'h2;  // rate, divide, clock out
   localparam logic [ADDR_W-1:0] ADDR_DATA = 3'h3;   // conversion result, read only
   localparam logic [ADDR_W-1:0] ADDR_OFS0 = 3'h4;   // offset coefficient, channel 0
   localparam logic [ADDR_W-1:0] ADDR_GAIN0 = 3'h5;  // gain coefficient, channel 0
   localparam logic [ADDR_W-1:0] ADDR_OFS1 = 3'h6;   // offset coefficient, channel 1
   localparam logic [ADDR_W-1:0] ADDR_GAIN1 = 3'h7;  // gain coefficient, channel 1

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int COMM_PD = 0;                  // power_down_request
   localparam int COMM_CHAN = 1;                // channel select
   localparam int COMM_RV = 7;                  // result_valid_n mirror
   localparam int SETUP_HOLD = 0;               // filter_hold
   localparam int SETUP_BIP = 1;                // bipolar coding
   localparam int SETUP_MODE_LO = 2;            // mode_select_low
   localparam int SETUP_MODE_HI = 3;            // mode_select_high
   localparam int CLOCK_FS0 = 0;                // filter select low
   localparam int CLOCK_FS1 = 1;                // filter select high
   localparam int CLOCK_DIV = 2;                // clock_divide_bit
   localparam int CLOCK_DIS = 3;                // clock_out_disable
   localparam int CLOCK_RNG = 4;                // clock range column

   // ----------------------------------------------------------------
   // modes and timing
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_NORMAL = 2'h0;   // free running conversion
   localparam logic [1:0] MODE_SELF = 2'h1;     // self-calibration
   localparam logic [1:0] MODE_ZERO = 2'h2;     // zero-scale system calibration
   localparam logic [1:0] MODE_FULL = 2'h3;     // full-scale system calibration
   localparam int SELF_CAL_PERIODS = 6;         // self-calibration length
   localparam int SELF_HALF_PERIODS = 3;        // zero half of self-calibration
   localparam int SELF_CONV_PERIODS = 3;        // conversion after self-cal
   localparam int SYS_CAL_PERIODS = 3;          // system calibration length
   localparam int SYS_CONV_PERIODS = 1;         // conversion after system cal
   localparam int FIRST_CONV_PERIODS = 3;       // first result after restart
   localparam int MOD_CYCLES_DEF = 128;         // master clocks per modulator cycle
   localparam int TP_CYCLES = 32'h7d0;          // pipeline delay, master clocks
   localparam logic [PULSE_W-1:0] PULSE_CYCLES = 10'h1f4;  // overwrite pulse
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;      // reset of data words
   localparam logic [DATA_W-1:0] GAIN_RST = 16'h8000;      // arbitrary neutral gain

   // decimation rate, indexed by {range, fs1, fs0}
   localparam logic [7:0][8:0] DEC_TABLE = {9'h026, 9'h04d, 9'h140, 9'h180,
                                            9'h027, 9'h04e, 9'h139, 9'h187};

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {S_HOLD, S_CAL, S_FIRST, S_RUN, S_PDOWN} seq_e;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;                  // register index
      logic [DATA_W-1:0] wdata;                 // write data
      logic wr;                                 // write strobe
      logic rd;                                 // read strobe
   } bus_req_s;

   typedef struct packed {
      seq_e state;                              // sequencer state
      logic [WAIT_W-1:0] wait_cnt;              // cycles left in current step
      logic [PULSE_W-1:0] pulse_cnt;            // overwrite pulse remaining
      logic rv_n;                               // result_valid_n
      logic unread;                             // result not yet read
      logic [1:0] mode;                         // {mode_select_high, mode_select_low}
      logic [1:0] cal_kind;                     // calibration in progress
      logic hold;                               // filter_hold
      logic bipolar;                            // bipolar coding
      logic chan;                               // selected channel
      logic pd;                                 // power_down_request
      logic [1:0] fs;                           // filter select
      logic rng;                                // clock range
      logic div;                                // clock_divide_bit
      logic clk_dis;                            // clock_out_disable
      logic clk_out;                            // clock_output_pin level
      logic mod_reset;                          // filter and modulator reset
      logic [DATA_W-1:0] data;                  // conversion result
      logic [1:0][DATA_W-1:0] offset;           // offset coefficients
      logic [1:0][DATA_W-1:0] gain;             // gain coefficients
      logic [DATA_W-1:0] rdata;                 // read data
   } seq_s;
endpackage

// ===== dv/host_model.sv
`timescale 1ns/10ps
module host_model
   import adc_seq_pkg::*;
(
   input wire logic i_clk,
   output logic [ADDR_W-1:0] o_addr,
   output logic [DATA_W-1:0] o_wdata,
   output logic o_wr,
   output logic o_rd
);
   // bus idle at time zero
   initial begin
      {o_addr, o_wdata, o_wr, o_rd} = '0;
   end
   // one-cycle write; data inverted on release
   task wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_wdata <= ~d;
   endtask
   // one-cycle read strobe
   task rd_reg(input logic [ADDR_W-1:0] a);
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
   endtask
endmodule // host_model

// ===== dv/tb.sv
`timescale 1ns/10ps
module tb;
   import adc_seq_pkg::*;
   localparam int P = 38;  // rate 38, one clock per modulator cycle
   logic I_CLK = 0, I_RST_B = 0, wr, rd, rd_d = 0, rvn, cko, mrst;
   logic [ADDR_W-1:0] a;
   logic [DATA_W-1:0] wd, rdat, smp = '0;
   logic [DATA_W-1:0] q[$];  // expected read data
   int n_mismatch = 0, checks = 0, cyc = 0, n;
   adc_cal_seq #(.MOD_CYCLES(1)) u_dut (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_ADDR(a), .I_WDATA(wd),
      .I_WR(wr), .I_RD(rd), .I_SAMPLE(smp), .O_RDATA(rdat), .O_RESULT_VALID_N(rvn),
      .O_CLOCK_OUTPUT_PIN(cko), .O_MOD_RESET(mrst));
   host_model u_host (.i_clk(I_CLK), .o_addr(a), .o_wdata(wd), .o_wr(wr), .o_rd(rd));
   initial forever #10 I_CLK = ~I_CLK;
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", s, e, g);
      end
   endtask
   task rdx(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] e);
      q.push_back(e);
      u_host.rd_reg(ad);
   endtask
   // count edges until the flag falls; zero skips the compare
   task waitlow(input int e);
      n = 0;
      do begin
         @(posedge I_CLK);
         #1 n++;
      end while (rvn !== 1'b0 && n < 9000);
      if (e > 0) chk("cycles", e, n);
      if (rvn !== 1'b0) chk("flagfall", 0, rvn);  // limit ran out
   endtask
   task tally_and_finish;
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // read data scoreboard, one cycle after the strobe
   always @(posedge I_CLK) begin
      rd_d <= rd;
      if (rd_d) chk("rdata", q.pop_front(), rdat);
   end
   // hang guard
   always @(posedge I_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         tally_and_finish;
      end
   end
   initial begin
      void'($urandom(32'ha6f3));
      repeat (4) @(posedge I_CLK);
      I_RST_B <= 1'b1;
      rdx(ADDR_SETUP, 16'h0001);
      rdx(ADDR_GAIN0, GAIN_RST);
      u_host.wr_reg(ADDR_CLOCK, 16'h0013);
      u_host.wr_reg(ADDR_COMM, 16'h0000);
      for (int m = 1; m < 4; m++) begin
         smp <= DATA_W'($urandom);
         if (m > 1) waitlow(0);  // flag low when the command comes
         u_host.wr_reg(ADDR_SETUP, 16'(m << 2));
         #1 chk("flag", 1, rvn);
         waitlow(m == 1 ? 9 * P : 4 * P);
         rdx(ADDR_SETUP, 16'h0000);
         rdx(ADDR_DATA, smp);
         if (m == 2) rdx(ADDR_OFS0, smp);
      end
      waitlow(0);
      repeat (P) @(posedge I_CLK);
      #1 chk("flag", 1, rvn);
      waitlow(P < int'(PULSE_CYCLES) ? P : int'(PULSE_CYCLES));
      u_host.wr_reg(ADDR_COMM, 16'h0001);
      repeat (3 * P) @(posedge I_CLK);
      #1 chk("flag", 0, rvn);
      chk("modrst", 1, mrst);
      n = cko;
      @(posedge I_CLK);
      #1 chk("clock_output_pin", !n, cko);
      rdx(ADDR_COMM, 16'h0001);
      rdx(ADDR_DATA, smp);
      repeat (3 * P) @(posedge I_CLK);
      #1 chk("flag", 1, rvn);
      rdx(ADDR_COMM, 16'h0081);
      u_host.wr_reg(ADDR_COMM, 16'h0000);
      waitlow(3 * P + TP_CYCLES);
      rdx(ADDR_DATA, smp);
      u_host.wr_reg(ADDR_CLOCK, 16'h001b);
      repeat (2) @(posedge I_CLK);
      #1 chk("clkoff", 0, cko);
      repeat (3) @(posedge I_CLK);
      tally_and_finish;
   end
endmodule // tb
